/* logic/agu_pkg.sv */
package agu_pkg;

    localparam int RAM_AW = 10;
    localparam int PC_W = 14;
    localparam int ROM_W = 10;
    localparam int NIB_W = 4;

    // data address map
    localparam logic [9:0] BANK_SEL_ADDR = 10'h03f;
    localparam logic [9:0] BANK_LO = 10'h090;
    localparam logic [9:0] BANK_HI = 10'h25f;
    localparam logic [9:0] SCRATCH_BASE = 10'h040;
    localparam logic [3:0] BANK_SEL_RESET = 4'h0;

    // program counter fields
    localparam int PAGE_LSB = 8;
    localparam int ZP_W = 6;
    localparam int TBL_FLAG_ACC = 8;
    localparam int TBL_FLAG_PORT = 9;
    localparam logic [13:0] PC_RESET = 14'h0000;

    // register-port offsets of this block
    localparam logic [9:0] REG_BANK_SEL = 10'h03f;
    localparam logic [9:0] REG_PC = 10'h000;
    localparam logic [9:0] REG_ACC = 10'h001;
    localparam logic [9:0] REG_SECOND = 10'h002;
    localparam logic [9:0] REG_LATCH_ONE = 10'h003;
    localparam logic [9:0] REG_LATCH_TWO = 10'h004;
    localparam logic [9:0] REG_IND_ADDR = 10'h005;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_SEQ,
        OP_RAM_INDIRECT,
        OP_RAM_DIRECT,
        OP_SCRATCH,
        OP_LONG_JUMP,
        OP_LONG_REL_JUMP,
        OP_FAR_SUB,
        OP_IN_PAGE_JUMP,
        OP_ZERO_PAGE,
        OP_TABLE_JUMP,
        OP_ROM_TABLE_LOAD
    } op_t;

    typedef struct packed {
        op_t op;
        logic [13:0] imm;
    } instr_t;

    typedef struct packed {
        logic valid;
        logic [3:0] bank;
        logic [9:0] addr;
    } ram_req_t;

endpackage

/* logic/bank_decode.sv */
`timescale 1ns/1ps
module bank_decode
    import agu_pkg::*;
(
    input wire logic [9:0] i_addr,
    input wire logic [3:0] i_bank_sel,
    input wire logic i_valid,
    output agu_pkg::ram_req_t o_req
);
    always_comb
    begin
        o_req.valid = i_valid;
        o_req.addr = i_addr;
        if (i_addr >= BANK_LO && i_addr <= BANK_HI)
        begin
            o_req.bank = i_bank_sel;
        end
        else
        begin
            o_req.bank = 4'h0;
        end
    end
endmodule

/* logic/address_generation_unit.sv */
`timescale 1ns/1ps
// Behaviour
// - indirect data address is hi, mid, low index registers joined to 10 bits
// - indirect accesses in banked region use bank select register at 03f
// - direct data instruction is two words; second word is the address
// - sixteen scratch nibbles at 040..04f used by scratch load and swap
// - long jumps and far subroutine entry load all 14 counter bits
// - program space is 64 pages of 256 words; low byte is word
// - in-page jump replaces the low eight bits of the already advanced counter
// - in-page jump at page offset 255 lands in the following page
// - zero-page entry loads bits 5..0 and clears bits 13..6
// - table jump target built from 4-bit immediate, accumulator, second operand
// - table load with bit 8 set writes low byte to accumulator pair
// - table load with bit 9 set writes low byte to both port latches
// - both flags set update accumulator pair and latches together
// - table load leaves counter sequential; table address only fetches data
module address_generation_unit
    import agu_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire agu_pkg::instr_t I_INSTR,
    input wire logic I_INSTR_VALID,
    input wire logic [9:0] I_SECOND_WORD,
    input wire logic [9:0] I_ROM_DATA,
    input wire logic I_ROM_DATA_VALID,
    input wire logic [3:0] I_IDX_HI,
    input wire logic [3:0] I_IDX_MID,
    input wire logic [3:0] I_IDX_LOW,
    input wire logic [9:0] I_REG_ADDR,
    input wire logic [3:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [13:0] O_REG_RDATA,
    output agu_pkg::ram_req_t O_RAM_REQ,
    output logic [13:0] O_PC,
    output logic [13:0] O_TABLE_ADDR,
    output logic O_TABLE_FETCH,
    output logic [3:0] O_ACC,
    output logic [3:0] O_SECOND,
    output logic [3:0] O_LATCH_ONE,
    output logic [3:0] O_LATCH_TWO
);
    import agu_pkg::*;

    logic [13:0] pc_q, pc_d;
    logic [3:0] bank_q, bank_d;
    logic [3:0] acc_q, acc_d;
    logic [3:0] second_q, second_d;
    logic [3:0] latch_one_q, latch_one_d;
    logic [3:0] latch_two_q, latch_two_d;
    logic [13:0] table_addr_q, table_addr_d;
    logic fetch_q, fetch_d;
    logic [13:0] rdata_q, rdata_d;
    logic [9:0] ram_addr;
    logic ram_valid;
    logic [13:0] pc_next_seq;
    ram_req_t ram_req;

    // table target shared by table jump and table load
    function automatic logic [13:0] table_target(input logic [3:0] imm,
                                                 input logic [3:0] acc,
                                                 input logic [3:0] sec);
        table_target = {2'b00, imm, sec, acc};
    endfunction

    // software write aimed at one register offset
    function automatic logic reg_write_hit(input logic wr,
                                           input logic [9:0] addr,
                                           input logic [9:0] off);
        reg_write_hit = wr && (addr == off);
    endfunction

    // fetched rom word carrying one route flag this cycle
    function automatic logic rom_claim(input logic valid,
                                       input logic [9:0] word,
                                       input int flag_bit);
        rom_claim = valid && word[flag_bit];
    endfunction

    assign pc_next_seq = pc_q + 14'h0001;

    // data address source select
    always_comb
    begin
        ram_addr = 10'h000;
        ram_valid = 1'b0;
        if (I_INSTR_VALID)
        begin
            unique case (I_INSTR.op)
                OP_RAM_INDIRECT:
                begin
                    ram_addr = {I_IDX_HI[1:0], I_IDX_MID, I_IDX_LOW};
                    ram_valid = 1'b1;
                end
                OP_RAM_DIRECT:
                begin
                    ram_addr = I_SECOND_WORD;
                    ram_valid = 1'b1;
                end
                OP_SCRATCH:
                begin
                    ram_addr = SCRATCH_BASE | {6'h00, I_INSTR.imm[3:0]};
                    ram_valid = 1'b1;
                end
                default:
                begin
                    ram_valid = 1'b0;
                end
            endcase
        end
    end

    bank_decode u_bank_decode (
        .i_addr(ram_addr),
        .i_bank_sel(bank_q),
        .i_valid(ram_valid),
        .o_req(ram_req)
    );

    // program counter
    always_comb
    begin
        pc_d = pc_q;
        if (I_INSTR_VALID)
        begin
            unique case (I_INSTR.op)
                OP_LONG_JUMP, OP_LONG_REL_JUMP, OP_FAR_SUB:
                begin
                    pc_d = I_INSTR.imm;
                end
                OP_IN_PAGE_JUMP:
                begin
                    // page taken from the already advanced counter
                    pc_d = {pc_next_seq[13:PAGE_LSB], I_INSTR.imm[7:0]};
                end
                OP_ZERO_PAGE:
                begin
                    pc_d = {8'h00, I_INSTR.imm[ZP_W-1:0]};
                end
                OP_TABLE_JUMP:
                begin
                    pc_d = table_target(I_INSTR.imm[3:0], acc_q, second_q);
                end
                OP_ROM_TABLE_LOAD:
                begin
                    pc_d = pc_next_seq;
                end
                default:
                begin
                    pc_d = pc_next_seq;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            pc_q <= PC_RESET;
        end
        else
        begin
            pc_q <= pc_d;
        end
    end

    // table fetch request, one-cycle pulse
    always_comb
    begin
        table_addr_d = table_addr_q;
        fetch_d = 1'b0;
        if (I_INSTR_VALID && (I_INSTR.op == OP_ROM_TABLE_LOAD))
        begin
            // table address feeds the fetch only, never the counter
            table_addr_d = table_target(I_INSTR.imm[3:0], acc_q, second_q);
            fetch_d = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            table_addr_q <= 14'h0000;
            fetch_q <= 1'b0;
        end
        else
        begin
            table_addr_q <= table_addr_d;
            fetch_q <= fetch_d;
        end
    end

    // accumulator pair; fetched word lands one or more cycles after the request
    // table load wins over a same-cycle software write
    always_comb
    begin
        acc_d = acc_q;
        second_d = second_q;
        if (rom_claim(I_ROM_DATA_VALID, I_ROM_DATA, TBL_FLAG_ACC))
        begin
            acc_d = I_ROM_DATA[3:0];
            second_d = I_ROM_DATA[7:4];
        end
        else if (reg_write_hit(I_REG_WR, I_REG_ADDR, REG_ACC))
        begin
            acc_d = I_REG_WDATA;
        end
        else if (reg_write_hit(I_REG_WR, I_REG_ADDR, REG_SECOND))
        begin
            second_d = I_REG_WDATA;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            acc_q <= 4'h0;
            second_q <= 4'h0;
        end
        else
        begin
            acc_q <= acc_d;
            second_q <= second_d;
        end
    end

    // port latches, table load only
    always_comb
    begin
        latch_one_d = latch_one_q;
        latch_two_d = latch_two_q;
        if (rom_claim(I_ROM_DATA_VALID, I_ROM_DATA, TBL_FLAG_PORT))
        begin
            latch_one_d = I_ROM_DATA[3:0];
            latch_two_d = I_ROM_DATA[7:4];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            latch_one_q <= 4'h0;
            latch_two_q <= 4'h0;
        end
        else
        begin
            latch_one_q <= latch_one_d;
            latch_two_q <= latch_two_d;
        end
    end

    // bank select, software owned
    always_comb
    begin
        bank_d = bank_q;
        if (reg_write_hit(I_REG_WR, I_REG_ADDR, REG_BANK_SEL))
        begin
            bank_d = I_REG_WDATA;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            bank_q <= BANK_SEL_RESET;
        end
        else
        begin
            bank_q <= bank_d;
        end
    end

    // read port, data one cycle after the strobe
    always_comb
    begin
        rdata_d = 14'h0000;
        if (I_REG_RD)
        begin
            unique case (I_REG_ADDR)
                REG_BANK_SEL: rdata_d = {10'h000, bank_q};
                REG_PC: rdata_d = pc_q;
                REG_ACC: rdata_d = {10'h000, acc_q};
                REG_SECOND: rdata_d = {10'h000, second_q};
                REG_LATCH_ONE: rdata_d = {10'h000, latch_one_q};
                REG_LATCH_TWO: rdata_d = {10'h000, latch_two_q};
                REG_IND_ADDR: rdata_d = {4'h0, I_IDX_HI[1:0], I_IDX_MID, I_IDX_LOW};
                default: rdata_d = 14'h0000;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            rdata_q <= 14'h0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign O_RAM_REQ = ram_req;
    assign O_PC = pc_q;
    assign O_TABLE_ADDR = table_addr_q;
    assign O_TABLE_FETCH = fetch_q;
    assign O_ACC = acc_q;
    assign O_SECOND = second_q;
    assign O_LATCH_ONE = latch_one_q;
    assign O_LATCH_TWO = latch_two_q;
    assign O_REG_RDATA = rdata_q;
endmodule

/* bench/agu_asserts.sv */
`timescale 1ns/1ps
module agu_asserts
    import agu_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire agu_pkg::instr_t I_INSTR,
    input wire logic I_INSTR_VALID,
    input wire logic [9:0] I_SECOND_WORD,
    input wire logic [9:0] I_ROM_DATA,
    input wire logic I_ROM_DATA_VALID,
    input wire logic [3:0] I_IDX_HI,
    input wire logic [3:0] I_IDX_MID,
    input wire logic [3:0] I_IDX_LOW,
    input wire agu_pkg::ram_req_t O_RAM_REQ,
    input wire logic [13:0] O_PC,
    input wire logic [13:0] O_TABLE_ADDR,
    input wire logic O_TABLE_FETCH,
    input wire logic [3:0] O_ACC,
    input wire logic [3:0] O_SECOND,
    input wire logic [3:0] O_LATCH_ONE,
    input wire logic [3:0] O_LATCH_TWO
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    op_t op_v;
    logic [13:0] pc_inc, tbl_tgt, page_tgt, zp_tgt;
    logic [7:0] rom_lo;
    assign op_v = I_INSTR_VALID ? I_INSTR.op : OP_NONE;
    assign pc_inc = O_PC + 14'h0001;
    assign tbl_tgt = {2'b00, I_INSTR.imm[3:0], O_SECOND, O_ACC};
    // target page comes from the counter already advanced by one (pc_inc)
    assign page_tgt = {pc_inc[13:8], I_INSTR.imm[7:0]};
    assign zp_tgt = {8'h00, I_INSTR.imm[5:0]};
    assign rom_lo = I_ROM_DATA[7:0];
    sequence s_fetch_out;
        O_TABLE_FETCH && O_TABLE_ADDR == $past(tbl_tgt) && O_PC == $past(pc_inc);
    endsequence
    chk_long_load: assert property ((op_v == OP_LONG_JUMP || op_v == OP_LONG_REL_JUMP
        || op_v == OP_FAR_SUB) |=> O_PC == $past(I_INSTR.imm)) else $error("long target");
    chk_page_jump: assert property (op_v == OP_IN_PAGE_JUMP
        |=> O_PC == $past(page_tgt)) else $error("in-page target");
    chk_zero_page: assert property (op_v == OP_ZERO_PAGE
        |=> O_PC == $past(zp_tgt)) else $error("zero-page target");
    chk_table_jump: assert property (op_v == OP_TABLE_JUMP
        |=> O_PC == $past(tbl_tgt)) else $error("table jump target");
    chk_tload_seq: assert property (op_v == OP_ROM_TABLE_LOAD
        |=> s_fetch_out) else $error("table load fetch or counter");
    chk_ram_indirect: assert property (op_v == OP_RAM_INDIRECT
        |-> O_RAM_REQ.addr == {I_IDX_HI[1:0], I_IDX_MID, I_IDX_LOW}) else $error("indirect");
    chk_scratch_addr: assert property (op_v == OP_SCRATCH
        |-> O_RAM_REQ.addr == {6'h04, I_INSTR.imm[3:0]}) else $error("scratch address");
    chk_bank_outside: assert property (O_RAM_REQ.valid && (O_RAM_REQ.addr < BANK_LO
        || O_RAM_REQ.addr > BANK_HI) |-> O_RAM_REQ.bank == 4'h0) else $error("bank outside");
    chk_acc_load: assert property (I_ROM_DATA_VALID && I_ROM_DATA[8]
        |=> {O_SECOND, O_ACC} == $past(rom_lo)) else $error("acc pair load");
    chk_direct_addr: assert property (op_v == OP_RAM_DIRECT
        |-> O_RAM_REQ.addr == I_SECOND_WORD) else $error("direct address");
    chk_latch_load: assert property (I_ROM_DATA_VALID && I_ROM_DATA[9]
        |=> {O_LATCH_TWO, O_LATCH_ONE} == $past(rom_lo)) else $error("latch pair load");
    chk_rom_idle: assert property (I_ROM_DATA_VALID && I_ROM_DATA[9:8] == 2'b00
        |=> $stable({O_LATCH_TWO, O_LATCH_ONE})) else $error("latches moved");
endmodule
bind address_generation_unit agu_asserts i_chk (.I_SYS_CLK, .I_NRST, .I_INSTR,
    .I_INSTR_VALID, .I_SECOND_WORD, .I_ROM_DATA, .I_ROM_DATA_VALID, .I_IDX_HI, .I_IDX_MID,
    .I_IDX_LOW, .O_RAM_REQ, .O_PC, .O_TABLE_ADDR, .O_TABLE_FETCH, .O_ACC, .O_SECOND,
    .O_LATCH_ONE, .O_LATCH_TWO);

/* bench/address_generation_unit_tb.sv */
`timescale 1ns/1ps
module address_generation_unit_tb;
    import agu_pkg::*;
    logic clk = 0, nrst = 0, iv = 0, rv = 0, wr = 0, rd = 0, tf;
    instr_t instr = '0;
    logic [9:0] sw = '0, rom = '0, ra = '0;
    logic [3:0] hi = '0, mid = '0, lo = '0, wd = '0, acc, sec, l1, l2;
    logic [13:0] rdata, pc, taddr;
    ram_req_t req;
    int fail_count = 0, checked = 0;
    op_t lj[3] = '{OP_LONG_JUMP, OP_LONG_REL_JUMP, OP_FAR_SUB};
    logic [9:0] rw[4] = '{10'h1c3, 10'h2e7, 10'h3b9, 10'h051};
    logic [15:0] ex[4] = '{16'h00c3, 16'he7c3, 16'hb9b9, 16'hb9b9};
    address_generation_unit i_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_INSTR(instr),
        .I_INSTR_VALID(iv), .I_SECOND_WORD(sw), .I_ROM_DATA(rom), .I_ROM_DATA_VALID(rv),
        .I_IDX_HI(hi), .I_IDX_MID(mid), .I_IDX_LOW(lo), .I_REG_ADDR(ra), .I_REG_WDATA(wd),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_RAM_REQ(req), .O_PC(pc),
        .O_TABLE_ADDR(taddr), .O_TABLE_FETCH(tf), .O_ACC(acc), .O_SECOND(sec),
        .O_LATCH_ONE(l1), .O_LATCH_TWO(l2));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one-cycle strobes; data settle #1 after the edge
    task exec(input op_t op, input logic [13:0] imm);
        @(posedge clk);
        instr <= '{op, imm};
        iv <= 1'b1;
        @(posedge clk);
        iv <= 1'b0;
        #1;
    endtask
    task ram(input op_t op, input logic [13:0] imm, input logic [13:0] e);
        @(posedge clk);
        instr <= '{op, imm};
        iv <= 1'b1;
        #1 chk({req.bank, req.addr}, e);
        @(posedge clk);
        iv <= 1'b0;
    endtask
    task reg_wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task reg_rd(input logic [9:0] a, input logic [13:0] e);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task rom_ld(input logic [9:0] d);
        @(posedge clk);
        rom <= d;
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
        #1;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        reg_rd(REG_PC, PC_RESET);
        reg_rd(REG_BANK_SEL, {10'h000, BANK_SEL_RESET});
        for (int i = 0; i < 3; i++)
        begin
            exec(lj[i], 14'h10ff + 14'(i << 12));
            chk(pc, 14'h10ff + 14'(i << 12));
        end
        exec(OP_IN_PAGE_JUMP, 14'h0034);
        chk(pc, 14'h3134);
        exec(OP_IN_PAGE_JUMP, 14'h3f12);
        chk(pc, 14'h3112);
        exec(OP_ZERO_PAGE, 14'h3fff);
        chk(pc, 14'h003f);
        exec(OP_SEQ, 14'h0000);
        chk(pc, 14'h0040);
        reg_wr(REG_ACC, 4'h5);
        reg_wr(REG_SECOND, 4'ha);
        reg_rd(REG_ACC, 14'h0005);
        reg_rd(REG_SECOND, 14'h000a);
        exec(OP_TABLE_JUMP, 14'h0003);
        chk(pc, 14'h03a5);
        exec(OP_ROM_TABLE_LOAD, 14'h0006);
        chk(pc, 14'h03a6);
        for (int n = 0; n < 4 && tf !== 1'b1; n++) @(posedge clk) #1;
        chk({tf, taddr}, 15'h46a5);
        @(posedge clk);
        #1 chk({15'h0000, tf}, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            rom_ld(rw[i]);
            chk({l2, l1, sec, acc}, ex[i]);
        end
        // table load and software write to the accumulator in one cycle
        @(posedge clk);
        ra <= REG_ACC;
        wd <= 4'h1;
        wr <= 1'b1;
        rom <= 10'h142;
        rv <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rv <= 1'b0;
        #1 chk({8'h00, sec, acc}, 16'h0042);
        reg_rd(REG_LATCH_ONE, 14'h0009);
        reg_rd(REG_LATCH_TWO, 14'h000b);
        reg_wr(REG_BANK_SEL, 4'h7);
        reg_rd(REG_BANK_SEL, 14'h0007);
        @(posedge clk);
        hi <= 4'h2;
        mid <= 4'h5;
        lo <= 4'hf;
        ram(OP_RAM_INDIRECT, 14'h0000, {4'h7, 10'h25f});
        mid <= 4'h6;
        lo <= 4'h0;
        ram(OP_RAM_INDIRECT, 14'h0000, {4'h0, 10'h260});
        sw <= 10'h090;
        ram(OP_RAM_DIRECT, 14'h0000, {4'h7, 10'h090});
        ram(OP_SCRATCH, 14'h000f, {4'h0, 10'h04f});
        reg_rd(REG_IND_ADDR, 14'h0260);
        reg_rd(10'h3ff, 14'h0000);
        wrap_up();
    end
endmodule
